// [hw/display_byte_code_dispatcher.v]
// Purpose: Sort host bytes into commands, custom glyphs, glyphs and direct writes
// Assumes: Host bytes come from logic on clk, one per in_valid cycle
// Notes:   Outputs are one-cycle pulses with registered data
// Contract
// R1: printable code shows glyph at cursor
// R2: codes 0 to 31 go to commands; the code takes 0x1E as the direct-write prefix instead
// R3: codes 128..135 select custom glyph 0..7
// R4: other high codes show extended glyphs
// R5: prefix, location one, code writes memory
// R6: location selects basic, memory or extended
// R7: prefix parameters never commands or glyphs
`timescale 1ns/100ps
`include "dispatch_consts.vh"
module display_byte_code_dispatcher (
   clk,
   reset,
   in_valid,
   in_byte,
   cmd_valid_r,
   cmd_code_r,
   glyph_valid_r,
   glyph_code_r,
   custom_valid_r,
   custom_index_r,
   direct_valid_r,
   register_select_line_r,
   extended_instruction_select_r,
   direct_data_r
);
   input  wire       clk;                            // 50 MHz clock
   input  wire       reset;                          // Synchronous, active high
   input  wire       in_valid;                       // Byte present this cycle
   input  wire [7:0] in_byte;                        // Byte from host
   output reg        cmd_valid_r;                    // Pulse: byte to command handler
   output reg  [7:0] cmd_code_r;                     // Command code
   output reg        glyph_valid_r;                  // Pulse: show glyph at cursor
   output reg  [7:0] glyph_code_r;                   // Glyph lookup index
   output reg        custom_valid_r;                 // Pulse: show custom glyph
   output reg  [2:0] custom_index_r;                 // Custom glyph number
   output reg        direct_valid_r;                 // Pulse: direct controller write
   output reg        register_select_line_r;         // 1 = data memory, 0 = control
   output reg        extended_instruction_select_r;  // Extended instruction mode
   output reg  [7:0] direct_data_r;                  // Byte written unchanged

   // Limitation: one byte is taken per in_valid cycle; prefix and location
   // bytes give no pulse, only the data byte of a direct write does
   reg [1:0] state_r;                                // Prefix sequence state
   reg [7:0] loc_r;                                  // Captured location byte

   // Next values, worked out combinationally and registered on every edge
   reg [1:0] state_nxt;                              // Next sequence state
   reg [7:0] loc_nxt;                                // Next location byte
   reg       cmd_valid_nxt;                          // Next command pulse
   reg [7:0] cmd_code_nxt;                           // Next command code
   reg       glyph_valid_nxt;                        // Next glyph pulse
   reg [7:0] glyph_code_nxt;                         // Next glyph index
   reg       custom_valid_nxt;                       // Next custom glyph pulse
   reg [2:0] custom_index_nxt;                       // Next custom glyph number
   reg       direct_valid_nxt;                       // Next direct write pulse
   reg       register_select_line_nxt;               // Next memory or control select
   reg       extended_instruction_select_nxt;        // Next instruction mode select
   reg [7:0] direct_data_nxt;                        // Next direct write byte
   wire [1:0] byte_class_w;                          // Class of the byte on in_byte

   // Direct-write sequence states, binary coded
   localparam [1:0] ST_IDLE     = 2'h0;              // Sorting ordinary bytes
   localparam [1:0] ST_LOCATION = 2'h1;              // Next byte is the location
   localparam [1:0] ST_DATA     = 2'h2;              // Next byte is the data

   // Classes of a byte seen outside a direct-write sequence
   localparam [1:0] CLASS_PREFIX = 2'h0;             // Opens a direct write
   localparam [1:0] CLASS_CMD    = 2'h1;             // Goes to the command handler
   localparam [1:0] CLASS_CUSTOM = 2'h2;             // User-defined glyph
   localparam [1:0] CLASS_GLYPH  = 2'h3;             // Printable or extended glyph

   // Decoding helpers; each is pure and holds no state
   // True for the eight user-defined glyph codes
   function is_custom;
      input [7:0] code;                              // Received byte
      begin
         is_custom = (code >= `CUSTOM_FIRST) && (code <= `CUSTOM_LAST);  // see R3
      end
   endfunction

   // Custom glyph number is the code minus the first custom code; the
   // subtraction ties the mapping to that code rather than to bit positions
   function [2:0] custom_number;
      input [7:0] code;                              // Byte already known to be custom
      reg   [7:0] diff;                              // Full-width difference
      begin
         diff          = code - `CUSTOM_FIRST;
         // Only eight custom codes exist, so the upper bits are zero and cut on purpose
         custom_number = diff[2:0];                  // see R3
      end
   endfunction

   // Sort a byte that arrives outside a direct-write sequence
   function [1:0] byte_class;
      input [7:0] code;                              // Received byte
      begin
         if (code == `DIRECT_PREFIX) begin
            // Tested first: the prefix sits inside the command range
            byte_class = CLASS_PREFIX;               // see R7
         end else if (code < `CMD_LIMIT) begin
            byte_class = CLASS_CMD;                  // see R2
         end else if (is_custom(code)) begin
            byte_class = CLASS_CUSTOM;               // see R3
         end else begin
            // Printable codes and every high code beyond the custom range
            byte_class = CLASS_GLYPH;                // see R1 (see R4)
         end
      end
   endfunction

   // Only three controller targets exist; a location naming any other is dropped
   function is_location_known;
      input [7:0] loc;                               // Captured location byte
      begin
         is_location_known = (loc == `LOC_CTRL_BASIC) || (loc == `LOC_DATA_MEM) ||
                             (loc == `LOC_CTRL_EXT);  // see R6
      end
   endfunction

   // Class decode of the incoming byte, read by the idle branch
   assign byte_class_w = byte_class(in_byte);

   // Next-value logic: pulses default low, data and selects hold their value.
   // Hazard: a prefix code arriving as the data byte is written, never taken
   // as a new prefix. Trade-off: splitting next values from registers costs
   // lines but keeps every output a flip-flop while the decode stays readable.
   always @* begin
      state_nxt                       = state_r;
      loc_nxt                         = loc_r;
      cmd_valid_nxt                   = `FLAG_OFF;
      cmd_code_nxt                    = cmd_code_r;
      glyph_valid_nxt                 = `FLAG_OFF;
      glyph_code_nxt                  = glyph_code_r;
      custom_valid_nxt                = `FLAG_OFF;
      custom_index_nxt                = custom_index_r;
      direct_valid_nxt                = `FLAG_OFF;
      register_select_line_nxt        = register_select_line_r;
      extended_instruction_select_nxt = extended_instruction_select_r;
      direct_data_nxt                 = direct_data_r;
      // Only the pulses fall while the host holds in_valid low; state and data hold
      if (in_valid) begin
         case (state_r)
            ST_LOCATION: begin
               // Any value is stored; it is judged when the data byte comes
               loc_nxt   = in_byte;                  // see R7
               state_nxt = ST_DATA;
            end
            ST_DATA: begin
               // Data byte closes the sequence whatever its value
               state_nxt = ST_IDLE;                  // see R7
               if (is_location_known(loc_r)) begin
                  direct_valid_nxt = `FLAG_ON;       // see R5
                  direct_data_nxt  = in_byte;        // see R5
               end
               if (loc_r == `LOC_CTRL_BASIC) begin
                  register_select_line_nxt        = `FLAG_OFF;  // see R6
                  extended_instruction_select_nxt = `FLAG_OFF;  // see R6
               end else if (loc_r == `LOC_DATA_MEM) begin
                  // Mode bit left as is, since memory writes ignore it
                  register_select_line_nxt = `FLAG_ON;          // see R5
               end else if (loc_r == `LOC_CTRL_EXT) begin
                  register_select_line_nxt        = `FLAG_OFF;  // see R6
                  extended_instruction_select_nxt = `FLAG_ON;   // see R6
               end
               // Unknown locations are swallowed: no pulse and no select change
            end
            default: begin
               // Idle, and the unused state code, which falls back to sorting
               state_nxt = ST_IDLE;
               if (byte_class_w == CLASS_PREFIX) begin
                  state_nxt = ST_LOCATION;           // see R7
               end else if (byte_class_w == CLASS_CMD) begin
                  cmd_valid_nxt = `FLAG_ON;          // see R2
                  cmd_code_nxt  = in_byte;
               end else if (byte_class_w == CLASS_CUSTOM) begin
                  custom_valid_nxt = `FLAG_ON;       // see R3
                  custom_index_nxt = custom_number(in_byte);
               end else begin
                  glyph_valid_nxt = `FLAG_ON;        // see R1 (see R4)
                  glyph_code_nxt  = in_byte;
               end
            end
         endcase
      end
   end

   // State and output registers; reset parks every output low.
   // Every register loads its next value on each edge, so no enable is needed.
   always @(posedge clk) begin
      if (reset) begin
         // Reset also abandons a half-received direct-write sequence
         state_r                       <= ST_IDLE;
         loc_r                         <= `BYTE_RESET;
         cmd_valid_r                   <= `FLAG_OFF;
         cmd_code_r                    <= `BYTE_RESET;
         glyph_valid_r                 <= `FLAG_OFF;
         glyph_code_r                  <= `BYTE_RESET;
         custom_valid_r                <= `FLAG_OFF;
         custom_index_r                <= `INDEX_RESET;
         direct_valid_r                <= `FLAG_OFF;
         register_select_line_r        <= `FLAG_OFF;
         extended_instruction_select_r <= `FLAG_OFF;
         direct_data_r                 <= `BYTE_RESET;
      end else begin
         // Pulses from the next-value logic last exactly one cycle
         state_r                       <= state_nxt;
         loc_r                         <= loc_nxt;
         cmd_valid_r                   <= cmd_valid_nxt;
         cmd_code_r                    <= cmd_code_nxt;
         glyph_valid_r                 <= glyph_valid_nxt;
         glyph_code_r                  <= glyph_code_nxt;
         custom_valid_r                <= custom_valid_nxt;
         custom_index_r                <= custom_index_nxt;
         direct_valid_r                <= direct_valid_nxt;
         register_select_line_r        <= register_select_line_nxt;
         extended_instruction_select_r <= extended_instruction_select_nxt;
         direct_data_r                 <= direct_data_nxt;
      end
   end
endmodule // display_byte_code_dispatcher

// [hw/dispatch_consts.vh]
// Purpose: Constants for the display byte code dispatcher
// Assumes: Byte-wide host stream, one byte per valid strobe
// Notes:   Definitions only
`ifndef DISPATCH_CONSTS_VH
`define DISPATCH_CONSTS_VH
`define CMD_LIMIT      8'h20
`define CUSTOM_FIRST   8'h80
`define CUSTOM_LAST    8'h87
`define DIRECT_PREFIX  8'h1E
`define LOC_CTRL_BASIC 8'h00
`define LOC_DATA_MEM   8'h01
`define LOC_CTRL_EXT   8'h02
`define BYTE_RESET     8'h00
`define INDEX_RESET    3'h0
`define FLAG_OFF       1'h0
`define FLAG_ON        1'h1
`endif

// [verif/host_byte_source.sv]
// Purpose: Host model feeding one byte per clock
// Assumes: Bytes launched 1 ns after the rising edge
// Notes: A released byte bus shows the inverted last byte
`timescale 1ns/100ps
module host_byte_source (clk, in_valid, in_byte);
   input  wire       clk;
   output reg        in_valid = 1'b0;
   output reg  [7:0] in_byte  = 8'h00;
   // Hold the byte through the next edge; sequence order is set by the caller
   task send(input [7:0] b);
      begin @(posedge clk); #1; in_valid = 1'b1; in_byte = b; end
   endtask
   // Release so a stale byte is never mistaken for live data
   task idle;
      begin @(posedge clk); #1; in_valid = 1'b0; in_byte = ~in_byte; end
   endtask
endmodule // host_byte_source

// [verif/display_byte_code_dispatcher_chk.sv]
// Purpose: Port checker; Assumes: single clk domain
// Notes: pend_r counts prefix parameter bytes still due
`timescale 1ns/100ps
module dispatch_chk (input wire clk, reset, in_valid, cmd_valid_r, glyph_valid_r, custom_valid_r,
   direct_valid_r, register_select_line_r, extended_instruction_select_r, input wire [7:0] in_byte,
   cmd_code_r, glyph_code_r, direct_data_r, input wire [2:0] custom_index_r);
   logic [1:0] pend_r;
   logic [7:0] loc_r;
   wire        t = in_valid && pend_r == 2'h0;  // Byte outside a direct sequence
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Track the two bytes owed after a prefix
   always @(posedge clk)
      if (reset) pend_r <= 2'h0;
      else if (in_valid) begin
         pend_r <= (pend_r != 2'h0) ? pend_r - 2'h1 : {in_byte == 8'h1E, 1'b0};
         if (pend_r == 2'h2) loc_r <= in_byte;
      end
   AST_GLYPH: assert property (t && in_byte inside {[8'h20:8'h7F]} |=>
      glyph_valid_r && glyph_code_r == $past(in_byte)) else $error("glyph wrong");
   AST_CMD: assert property (t && in_byte < 8'h20 && in_byte != 8'h1E |=>
      cmd_valid_r && cmd_code_r == $past(in_byte) && !glyph_valid_r) else $error("cmd wrong");
   AST_CUSTOM: assert property (t && in_byte inside {[8'h80:8'h87]} |=>
      custom_valid_r && custom_index_r == $past(in_byte[2:0])) else $error("custom wrong");
   AST_EXT: assert property (t && in_byte >= 8'h88 |=>
      glyph_valid_r && !custom_valid_r && glyph_code_r == $past(in_byte)) else $error("ext wrong");
   AST_DIRECT: assert property (in_valid && pend_r == 2'h1 && loc_r == 8'h01 |=>
      direct_valid_r && register_select_line_r && direct_data_r == $past(in_byte)) else $error("direct");
   AST_LOC: assert property (in_valid && pend_r == 2'h1 && loc_r inside {8'h00, 8'h02}
      |=> direct_valid_r && !register_select_line_r
      && extended_instruction_select_r == $past(loc_r[1])) else $error("location wrong");
   AST_PARAM: assert property (in_valid && pend_r != 2'h0 |=>
      !cmd_valid_r && !glyph_valid_r && !custom_valid_r) else $error("parameter leaked");
endmodule // dispatch_chk
bind display_byte_code_dispatcher dispatch_chk dispatch_chk_i (.clk(clk), .reset(reset),
   .in_valid(in_valid), .cmd_valid_r(cmd_valid_r), .glyph_valid_r(glyph_valid_r),
   .custom_valid_r(custom_valid_r), .direct_valid_r(direct_valid_r),
   .register_select_line_r(register_select_line_r),
   .extended_instruction_select_r(extended_instruction_select_r), .in_byte(in_byte),
   .cmd_code_r(cmd_code_r), .glyph_code_r(glyph_code_r), .direct_data_r(direct_data_r),
   .custom_index_r(custom_index_r));

// [verif/display_byte_code_dispatcher_test.sv]
// Purpose: Scenario bench; Assumes: outputs settle one edge after a byte
// Notes: Each check runs 1 ns after the edge that registers the answer
`timescale 1ns/100ps
module display_byte_code_dispatcher_test;
   logic clk = 1'b0, reset = 1'b1;
   wire in_valid, cmd_valid_r, glyph_valid_r, custom_valid_r, direct_valid_r;
   wire register_select_line_r, extended_instruction_select_r;
   wire [7:0] in_byte, cmd_code_r, glyph_code_r, direct_data_r;
   wire [2:0] custom_index_r;
   int num_errors = 0, cmp_count = 0;
   always #10 clk = ~clk;
   host_byte_source host_byte_source_i (.clk(clk), .in_valid(in_valid), .in_byte(in_byte));
   display_byte_code_dispatcher display_byte_code_dispatcher_i (
      .clk                           (clk),
      .reset                         (reset),
      .in_valid                      (in_valid),
      .in_byte                       (in_byte),
      .cmd_valid_r                   (cmd_valid_r),
      .cmd_code_r                    (cmd_code_r),
      .glyph_valid_r                 (glyph_valid_r),
      .glyph_code_r                  (glyph_code_r),
      .custom_valid_r                (custom_valid_r),
      .custom_index_r                (custom_index_r),
      .direct_valid_r                (direct_valid_r),
      .register_select_line_r        (register_select_line_r),
      .extended_instruction_select_r (extended_instruction_select_r),
      .direct_data_r                 (direct_data_r)
   );
   task chk(input string what, input logic [15:0] seen, exp);
      begin cmp_count++; if (seen !== exp) begin num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen); end end
   endtask
   task complete_run;
      begin $display("errors %0d compares %0d", num_errors, cmp_count);
         if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish; end
   endtask
   task put3(input [7:0] a, b, c);
      begin host_byte_source_i.send(a); host_byte_source_i.send(b);
         host_byte_source_i.send(c); host_byte_source_i.idle; end
   endtask
   // Printable, command then custom back to back, extended
   task sort_case;
      begin put3(8'h41, 8'h1F, 8'h87);
         chk("custom", {custom_valid_r, custom_index_r, cmd_code_r}, 16'h0F1F);
         host_byte_source_i.send(8'h41); host_byte_source_i.idle;
         chk("glyph", {glyph_valid_r, glyph_code_r}, 16'h0141);
         host_byte_source_i.send(8'h89); host_byte_source_i.idle;
         chk("ext", {glyph_valid_r, glyph_code_r}, 16'h0189); end
   endtask
   // Direct writes: data memory, extended, basic; prefix as data byte
   task direct_case;
      begin put3(8'h1E, 8'h01, 8'h16);
         chk("mem", {direct_valid_r, register_select_line_r, direct_data_r}, 16'h0316);
         put3(8'h1E, 8'h02, 8'h1E);
         chk("ext", {direct_valid_r, register_select_line_r, extended_instruction_select_r,
            cmd_valid_r, direct_data_r}, 16'h0A1E);
         put3(8'h1E, 8'h00, 8'h05);
         chk("basic", {direct_valid_r, register_select_line_r, extended_instruction_select_r,
            direct_data_r}, 16'h0405);
         // Unknown location: both parameters swallowed, data register holds
         put3(8'h1E, 8'h03, 8'h41);
         chk("unknown", {direct_valid_r, glyph_valid_r, cmd_valid_r,
            direct_data_r}, 16'h0005);
         host_byte_source_i.send(8'h41);
         host_byte_source_i.idle;
         chk("resume", {glyph_valid_r, glyph_code_r}, 16'h0141); end
   endtask
   // Reset in mid-sequence clears outputs and drops the pending prefix
   task reset_case;
      begin
         host_byte_source_i.send(8'h1E);
         host_byte_source_i.idle;
         reset = 1'b1;
         repeat (2) @(posedge clk);
         #1 reset = 1'b0;
         chk("reset", {direct_valid_r, direct_data_r}, 16'h0000);
         host_byte_source_i.send(8'h41);
         host_byte_source_i.idle;
         chk("after reset", {glyph_valid_r, glyph_code_r}, 16'h0141);
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      sort_case;
      direct_case;
      reset_case;
      complete_run;
   end
endmodule // display_byte_code_dispatcher_test
